// ---- core/saivp_pkg.sv ----
// Constants shared by the serial audio input and volume path.
// Assumes the control port decodes byte addresses onto a plain register port.
package saivp_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_FILTER  = 8'h02;
  localparam logic [7:0] ADDR_FORMAT  = 8'h03;
  localparam logic [7:0] ADDR_VOLUME  = 8'h04;
  localparam logic [7:0] ADDR_VOLCFG  = 8'h05;
  localparam logic [7:0] ADDR_STATUS  = 8'h06;
  localparam logic [7:0] ADDR_APPLIED = 8'h07;
  // Field positions
  localparam int BIT_BYPASS  = 7;
  localparam int BIT_DSPEED  = 3;
  localparam int BIT_RAMPOFF = 7;
  // Reset values
  localparam logic [7:0] RST_FILTER = 8'h01;
  localparam logic [7:0] RST_FORMAT = 8'h00;
  localparam logic [7:0] RST_VOLUME = 8'hcf;
  localparam logic [7:0] RST_VOLCFG = 8'h00;
  // Framing codes
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ  = 2'h1;
  localparam logic [1:0] FMT_RJ  = 2'h2;
  // Word length codes: 24, 20, 18, 16 bits
  localparam logic [1:0] LEN_24 = 2'h0;
  localparam logic [1:0] LEN_20 = 2'h1;
  localparam logic [1:0] LEN_18 = 2'h2;
  // Slot lengths for 32, 48 and 64 times the sample rate
  localparam logic [5:0] SLOT_16 = 6'h10;
  localparam logic [5:0] SLOT_24 = 6'h18;
  localparam logic [5:0] SLOT_32 = 6'h20;
  // Gain and ramp
  localparam logic [7:0] VOL_UNITY   = 8'hcf;
  localparam logic [7:0] VOL_MUTE    = 8'h00;
  localparam logic [1:0] BOOST_HW    = 2'h1;
  localparam logic [2:0] RAMP_FRAMES = 3'h7;
  localparam logic [8:0] VOL_BIAS    = 9'h02d;
  localparam logic [5:0] VOL_SHIFT0  = 6'h28;
  // High-pass pole shift and DC watchdog
  localparam int         HPF_SHIFT = 10;
  localparam logic [22:0] DC_THRESH = 23'h400000;
  localparam logic [11:0] DC_RUN    = 12'h800;
endpackage : saivp_pkg

// ---- core/saivp_rx.sv ----
// Serial audio receiver: link logic on the bit clock, toggle crossing to clk.
// Assumes config inputs are quasi-static and change only while audio is idle.
`timescale 1ns/1ps
module saivp_rx (
  // System side
  input  wire  logic        clk,
  input  wire  logic        rst,
  input  wire  logic [1:0]  cfg_fmt,
  input  wire  logic [1:0]  cfg_len,
  input  wire  logic        cfg_ratio_chk,
  // Link
  input  wire  logic        bit_clk,
  input  wire  logic        channel_select_clock,
  input  wire  logic        serial_data,
  // Sample out
  output logic              rx_valid,
  output logic              rx_left,
  output logic [23:0]       rx_data
);
  logic [1:0]  lrst_q;
  logic [4:0]  cfg_s1_q, cfg_s2_q;
  logic        lr_dly_q, frame_prev_q, tog_q, tog_d, left_q, left_d;
  logic [23:0] sr_q, sr_d, word_q, word_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [2:0]  tsync_q;
  logic        valid_q;
  logic        lrst, frame_lr, edge_seen, i2s, rj, ratio_ok;
  logic [4:0]  keep;
  logic [23:0] lj_word, mask_lj, mask_rj;

  // Reset level carried into the link domain
  always_ff @(posedge bit_clk) begin
    lrst_q   <= {lrst_q[0], rst};
    cfg_s1_q <= {cfg_ratio_chk, cfg_len, cfg_fmt};
    cfg_s2_q <= cfg_s1_q;
  end
  assign lrst = lrst_q[1];
  assign i2s  = cfg_s2_q[1:0] == saivp_pkg::FMT_I2S;
  assign rj   = cfg_s2_q[1:0] == saivp_pkg::FMT_RJ;

  // Standard framing is left-aligned framing one bit late
  assign frame_lr  = i2s ? lr_dly_q : channel_select_clock;
  assign edge_seen = frame_lr != frame_prev_q;
  assign ratio_ok  = cnt_q == saivp_pkg::SLOT_16 || cnt_q == saivp_pkg::SLOT_24 ||
                     cnt_q == saivp_pkg::SLOT_32;

  always_comb begin
    case (cfg_s2_q[3:2])
      saivp_pkg::LEN_24: keep = 5'd24;
      saivp_pkg::LEN_20: keep = 5'd20;
      saivp_pkg::LEN_18: keep = 5'd18;
      default:           keep = 5'd16;
    endcase
    mask_rj = 24'hffffff >> (5'd24 - keep);
    mask_lj = 24'hffffff << (5'd24 - keep);
    if (cnt_q < saivp_pkg::SLOT_24) begin
      lj_word = sr_q << (5'd24 - cnt_q[4:0]);
    end else begin
      lj_word = sr_q;
    end
    sr_d   = sr_q;
    cnt_d  = cnt_q;
    word_d = word_q;
    left_d = left_q;
    tog_d  = tog_q;
    if (edge_seen) begin
      // Data bit at the slot edge is the new word's first bit
      sr_d  = {23'h000000, serial_data};
      cnt_d = 6'h01;
      if (cnt_q != 6'h00 && (!cfg_s2_q[4] || ratio_ok)) begin
        word_d = rj ? (sr_q & mask_rj) : (lj_word & mask_lj);
        left_d = i2s ? !frame_prev_q : frame_prev_q;
        tog_d  = !tog_q;
      end
    end else begin
      if (rj || cnt_q < saivp_pkg::SLOT_24) begin
        sr_d = {sr_q[22:0], serial_data};
      end
      if (cnt_q != 6'h3f) begin
        cnt_d = cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge bit_clk) begin
    if (lrst) begin
      lr_dly_q     <= 1'b0;
      frame_prev_q <= 1'b0;
      sr_q         <= 24'h000000;
      cnt_q        <= 6'h00;
      word_q       <= 24'h000000;
      left_q       <= 1'b0;
      tog_q        <= 1'b0;
    end else begin
      lr_dly_q     <= channel_select_clock;
      frame_prev_q <= frame_lr;
      sr_q         <= sr_d;
      cnt_q        <= cnt_d;
      word_q       <= word_d;
      left_q       <= left_d;
      tog_q        <= tog_d;
    end
  end

  // Word and channel stay put for a whole slot, far longer than the crossing
  always_ff @(posedge clk) begin
    if (rst) begin
      tsync_q <= 3'h0;
      valid_q <= 1'b0;
      rx_left <= 1'b0;
      rx_data <= 24'h000000;
    end else begin
      tsync_q <= {tsync_q[1:0], tog_q};
      valid_q <= tsync_q[2] ^ tsync_q[1];
      if (tsync_q[2] ^ tsync_q[1]) begin
        rx_left <= left_q;
        rx_data <= word_q;
      end
    end
  end
  assign rx_valid = valid_q;
endmodule : saivp_rx

// ---- core/saivp_top.sv ----
// Serial audio input, DC-blocking filter, digital boost and ramped volume.
// Assumes a control-port decoder drives the register port and straps are static.
// Operation
// - Hardware mode forces single speed; software mode may select double speed.
// - Software mode uses the register port; shutdown, fault, clip pins still work.
// - Receiver takes three framings; hardware mode only standard with 32/48/64 ratios.
// - Standard framing: channel select low for left, high for right.
// - Standard framing: first bit one bit clock after channel select changes.
// - Two's complement, MSB first, bits captured on bit clock rising edge.
// - Left-aligned: high is left; first bit in the toggle bit period.
// - Left-aligned accepts 16 to 24 bits, trailing positions zero-filled.
// - Right-aligned: high is left; last bit just before channel select changes.
// - Right-aligned zero-fills unused leading bit positions.
// - High-pass filter first; always on in hardware mode, bypass bit in software.
// - Output DC fault shuts power stage down and latches a fault.
// - Boost follows the filter and precedes volume.
// - Hardware mode boost defaults to plus six decibels.
// - Volume spans mute to plus 24 dB in 0.5 dB steps.
// - Volume code equals 0xcf plus gain over 0.5 dB; 0xcf is unity.
// - Applied volume ramps 0.5 dB every 8 frames.
// - Ramp-off bit applies new volume at once.
`timescale 1ns/1ps
module saivp_top (
  // Clock and reset
  input  wire  logic        clk,
  input  wire  logic        rst,
  // Serial audio link
  input  wire  logic        bit_clk,
  input  wire  logic        channel_select_clock,
  input  wire  logic        serial_data,
  // Control pins
  input  wire  logic        hw_mode_pin,
  input  wire  logic        amp_shutdown_n,
  input  wire  logic        soft_clip_pin,
  output logic              amp_fault_n_o,
  output logic              amp_fault_n_oe_n,
  output logic              power_stage_en,
  output logic              double_speed,
  // Register port
  input  wire  logic        reg_write,
  input  wire  logic [7:0]  reg_addr,
  input  wire  logic [7:0]  reg_wdata,
  output logic [7:0]        reg_rdata,
  // Processed audio
  output logic              audio_valid,
  output logic              audio_left,
  output logic [23:0]       audio_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [2:0]  pin_s1_q, pin_s2_q;
  logic [7:0]  filt_q, filt_d, fmt_q, fmt_d, vol_q, vol_d, vcfg_q, vcfg_d, rdata_d;
  logic        hw, sd_s, clip_s, bypass, ramp_off;
  logic [1:0]  eff_fmt, boost;
  logic [7:0]  target;
  logic        rx_valid, rx_left;
  logic [23:0] rx_data;

  // Pins cross from outside: two flops before use
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {soft_clip_pin, amp_shutdown_n, hw_mode_pin};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign hw     = pin_s2_q[0];
  assign sd_s   = pin_s2_q[1];
  assign clip_s = pin_s2_q[2];

  // Register port; hardware mode overrides what was written
  always_comb begin
    filt_d = filt_q;
    fmt_d  = fmt_q;
    vol_d  = vol_q;
    vcfg_d = vcfg_q;
    if (reg_write) begin
      case (reg_addr)
        saivp_pkg::ADDR_FILTER: filt_d = reg_wdata;
        saivp_pkg::ADDR_FORMAT: fmt_d  = reg_wdata;
        saivp_pkg::ADDR_VOLUME: vol_d  = reg_wdata;
        saivp_pkg::ADDR_VOLCFG: vcfg_d = reg_wdata;
        default: ;
      endcase
    end
  end
  assign eff_fmt  = hw ? saivp_pkg::FMT_I2S : fmt_q[1:0];
  assign bypass   = !hw && filt_q[saivp_pkg::BIT_BYPASS];
  assign boost    = hw ? saivp_pkg::BOOST_HW : filt_q[1:0];
  assign target   = hw ? saivp_pkg::VOL_UNITY : vol_q;
  assign ramp_off = !hw && vcfg_q[saivp_pkg::BIT_RAMPOFF];

  saivp_rx u_rx (
    .clk                  (clk),
    .rst                  (rst),
    .cfg_fmt              (eff_fmt),
    .cfg_len              (hw ? saivp_pkg::LEN_24 : fmt_q[5:4]),
    .cfg_ratio_chk        (hw),
    .bit_clk              (bit_clk),
    .channel_select_clock (channel_select_clock),
    .serial_data          (serial_data),
    .rx_valid             (rx_valid),
    .rx_left              (rx_left),
    .rx_data              (rx_data)
  );

  function automatic logic [23:0] sat24(input logic signed [44:0] v);
    if (v > 45'sd8388607) begin
      sat24 = 24'h7fffff;
    end else if (v < -45'sd8388608) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction : sat24

  // Twelve steps of 2^(k/12) in Q1.15, one octave of half-dB steps
  function automatic logic [15:0] mant(input logic [3:0] r);
    case (r)
      4'h0: mant = 16'h8000;
      4'h1: mant = 16'h879c;
      4'h2: mant = 16'h8fad;
      4'h3: mant = 16'h9838;
      4'h4: mant = 16'ha145;
      4'h5: mant = 16'haadc;
      4'h6: mant = 16'hb505;
      4'h7: mant = 16'hbfc9;
      4'h8: mant = 16'hcb30;
      4'h9: mant = 16'hd745;
      4'ha: mant = 16'he412;
      4'hb: mant = 16'hf1a2;
      default: mant = 16'h8000;
    endcase
  endfunction : mant

  // DC-blocking filter, one pole per channel; wider state avoids limit cycles
  logic signed [25:0] xp_q [2];
  logic signed [25:0] yp_q [2];
  logic signed [25:0] y_w  [2];
  logic        hpf_valid_q, hpf_left_q;
  logic [23:0] hpf_q, hpf_d, hpf_y;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_hpf
      logic signed [25:0] xp_d, yp_d;
      logic               mine;
      assign mine = rx_valid && (rx_left == (ch == 0));
      always_comb begin
        y_w[ch] = 26'(signed'(rx_data)) - xp_q[ch] + yp_q[ch] - (yp_q[ch] >>> saivp_pkg::HPF_SHIFT);
        xp_d    = mine ? 26'(signed'(rx_data)) : xp_q[ch];
        yp_d    = mine ? y_w[ch] : yp_q[ch];
      end
      always_ff @(posedge clk) begin
        if (rst) begin
          xp_q[ch] <= 26'sd0;
          yp_q[ch] <= 26'sd0;
        end else begin
          xp_q[ch] <= xp_d;
          yp_q[ch] <= yp_d;
        end
      end
    end
  endgenerate
  assign hpf_y = sat24(45'(y_w[rx_left ? 0 : 1]));
  assign hpf_d = bypass ? rx_data : hpf_y;

  // Boost, then volume: gain = mant(r) * 2^(q-21) with q,r from code+45
  logic [7:0]  cur_q, cur_d;
  logic [2:0]  fcnt_q, fcnt_d;
  logic        step_now;
  logic [8:0]  u;
  logic [4:0]  q_idx;
  logic [3:0]  r_idx;
  logic [23:0] boosted, vol_out;
  logic signed [44:0] prod;
  assign boosted  = sat24(45'(signed'(hpf_q)) <<< boost);
  assign u        = {1'b0, cur_q} + saivp_pkg::VOL_BIAS;
  assign q_idx    = 5'(u / 9'd12);
  assign r_idx    = 4'(u % 9'd12);
  // Both factors widened first so the product keeps all its bits
  assign prod     = (45'(signed'(boosted)) * 45'(signed'({1'b0, mant(r_idx)}))) <<< 4;
  assign vol_out  = (cur_q == saivp_pkg::VOL_MUTE) ? 24'h000000 :
                    sat24(prod >>> (saivp_pkg::VOL_SHIFT0 - {1'b0, q_idx}));
  assign step_now = rx_valid && rx_left && fcnt_q == saivp_pkg::RAMP_FRAMES;

  always_comb begin
    fcnt_d = (rx_valid && rx_left) ? fcnt_q + 3'h1 : fcnt_q;
    cur_d  = cur_q;
    if (ramp_off) begin
      cur_d = target;
    end else if (step_now && cur_q < target) begin
      cur_d = cur_q + 8'h01;
    end else if (step_now && cur_q > target) begin
      cur_d = cur_q - 8'h01;
    end
  end

  // DC watchdog on the output: long run of one sign above threshold
  logic [11:0] run_q, run_d;
  logic        sign_q, sign_d, dc_q, dc_d, big;
  assign big = audio_data[23] ? (~audio_data[22:0] >= saivp_pkg::DC_THRESH)
                              : (audio_data[22:0] >= saivp_pkg::DC_THRESH);
  always_comb begin
    run_d  = run_q;
    sign_d = sign_q;
    if (audio_valid) begin
      sign_d = audio_data[23];
      run_d  = (big && audio_data[23] == sign_q) ? run_q + 12'h001 : 12'h000;
    end
    // Set wins over the shutdown clear
    dc_d = (run_q == saivp_pkg::DC_RUN) || (dc_q && sd_s);
  end

  always_comb begin
    case (reg_addr)
      saivp_pkg::ADDR_FILTER:  rdata_d = filt_q;
      saivp_pkg::ADDR_FORMAT:  rdata_d = fmt_q;
      saivp_pkg::ADDR_VOLUME:  rdata_d = vol_q;
      saivp_pkg::ADDR_VOLCFG:  rdata_d = vcfg_q;
      saivp_pkg::ADDR_STATUS:  rdata_d = {4'h0, double_speed, clip_s, hw, dc_q};
      saivp_pkg::ADDR_APPLIED: rdata_d = cur_q;
      default:                 rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filt_q           <= saivp_pkg::RST_FILTER;
      fmt_q            <= saivp_pkg::RST_FORMAT;
      vol_q            <= saivp_pkg::RST_VOLUME;
      vcfg_q           <= saivp_pkg::RST_VOLCFG;
      reg_rdata        <= 8'h00;
      hpf_q            <= 24'h000000;
      hpf_valid_q      <= 1'b0;
      hpf_left_q       <= 1'b0;
      audio_valid      <= 1'b0;
      audio_left       <= 1'b0;
      audio_data       <= 24'h000000;
      cur_q            <= saivp_pkg::VOL_UNITY;
      fcnt_q           <= 3'h0;
      run_q            <= 12'h000;
      sign_q           <= 1'b0;
      dc_q             <= 1'b0;
      amp_fault_n_oe_n <= 1'b1;
      power_stage_en   <= 1'b0;
      double_speed     <= 1'b0;
    end else begin
      filt_q           <= filt_d;
      fmt_q            <= fmt_d;
      vol_q            <= vol_d;
      vcfg_q           <= vcfg_d;
      reg_rdata        <= rdata_d;
      hpf_q            <= hpf_d;
      hpf_valid_q      <= rx_valid;
      hpf_left_q       <= rx_left;
      audio_valid      <= hpf_valid_q;
      audio_left       <= hpf_left_q;
      audio_data       <= vol_out;
      cur_q            <= cur_d;
      fcnt_q           <= fcnt_d;
      run_q            <= run_d;
      sign_q           <= sign_d;
      dc_q             <= dc_d;
      amp_fault_n_oe_n <= !dc_d;
      power_stage_en   <= sd_s && !dc_d;
      double_speed     <= !hw && fmt_q[saivp_pkg::BIT_DSPEED];
    end
  end
  // Open-drain: only ever pulls low
  assign amp_fault_n_o = 1'b0;

  hw_speed_a:   assert property (hw |=> !double_speed) else $error("double speed in hardware mode");
  hw_filter_a:  assert property (rx_valid && hw |=> hpf_q == $past(hpf_y) && !$past(bypass))
                  else $error("filter bypassed in hardware mode");
  hw_boost_a:   assert property (hw |-> boost == 2'h1) else $error("boost not +6 dB in hardware mode");
  dc_hold_a:    assert property ((dc_q && sd_s) ##1 sd_s |-> dc_q ##1 dc_q)
                  else $error("dc fault dropped without shutdown");
  dc_stage_a:   assert property (dc_q |=> !power_stage_en) else $error("power stage on during dc fault");
  unity_map_a:  assert property (cur_q == 8'hcf |-> q_idx == 5'd21 && r_idx == 4'd0)
                  else $error("0xcf is not unity gain");
  ramp_step_a:  assert property (!$past(ramp_off) && cur_q != $past(cur_q) |-> $past(step_now) &&
                  (cur_q - $past(cur_q) == 8'h01 || $past(cur_q) - cur_q == 8'h01))
                  else $error("ramp step not one half dB per 8 frames");
  ramp_off_a:   assert property (ramp_off ##1 ramp_off |-> cur_q == $past(target))
                  else $error("ramp-off did not apply volume at once");
  rx_pulse_a:   assert property (rx_valid |=> !rx_valid ##1 audio_valid)
                  else $error("sample strobe not one cycle or not passed on");
  hpf_to_out_a: assert property (hpf_valid_q |=> audio_valid) else $error("boost stage missed a sample");
  dc_set_a:     assert property (run_q == saivp_pkg::DC_RUN |=> dc_q)
                  else $error("dc run did not latch the fault");
  fault_pin_a:  assert property (!amp_fault_n_oe_n |-> !power_stage_en)
                  else $error("fault pin low with power stage on");
  mute_out_a:   assert property (hpf_valid_q && cur_q == saivp_pkg::VOL_MUTE |=> audio_data == 24'h000000)
                  else $error("mute code let audio through");
  hw_format_a:  assert property (hw |-> eff_fmt == saivp_pkg::FMT_I2S)
                  else $error("hardware mode not in standard framing");

  cov_lj_c:   cover property (eff_fmt == 2'h1 && audio_valid);
  cov_rj_c:   cover property (eff_fmt == 2'h2 && audio_valid);
  cov_ramp_c: cover property (step_now && cur_q != target);
  cov_dc_c:   cover property ($rose(dc_q));
endmodule : saivp_top

// ---- testbench/saivp_src_model.sv ----
// Behavioural audio source driving bit clock, channel select and data.
// Assumes format inputs are set while idle; the bit clock stands still between bursts.
`timescale 1ns/1ps
module saivp_src_model (
  // Format
  input  wire  logic [1:0]  fmt,
  input  wire  logic [5:0]  slot,
  input  wire  logic [4:0]  wlen,
  // Samples, word held in the top bits
  input  wire  logic [23:0] left,
  input  wire  logic [23:0] right,
  // Link
  output logic              bit_clk,
  output logic              channel_select_clock,
  output logic              serial_data
);
  initial begin
    bit_clk = 1'b0;
    channel_select_clock = 1'b1;
    serial_data = 1'b0;
  end

  // Unused bit positions carry the inverse of the previous bit, so zero fill is really tested
  task automatic send_frames(input int n);
    int sl;
    int pos;
    int k;
    logic [23:0] w;
    sl = int'(slot);
    for (int f = 0; f < n; f++) begin
      for (int p = 0; p < 2 * sl; p++) begin
        pos = (fmt == saivp_pkg::FMT_I2S) ? (p + 2 * sl - 1) % (2 * sl) : p;
        w = (pos < sl) ? left : right;
        k = pos % sl;
        if (fmt == saivp_pkg::FMT_RJ) begin
          k = k - (sl - 24);
        end
        bit_clk = 1'b0;
        channel_select_clock = (p < sl) ^ (fmt == saivp_pkg::FMT_I2S);
        serial_data = (k >= 0 && k < int'(wlen)) ? w[23 - k] : ~serial_data;
        #6;
        bit_clk = 1'b1;
        #6;
      end
    end
    bit_clk = 1'b0;
    serial_data = ~serial_data;
  endtask : send_frames
endmodule : saivp_src_model

// ---- testbench/saivp_top_tb.sv ----
// Self-checking bench for the audio input and volume path.
// Assumes the source model on the link and a plain register port.
`timescale 1ns/1ps
module saivp_top_tb;
  typedef struct {
    logic [1:0]  fmt;
    logic [1:0]  len;
    logic [5:0]  slot;
    logic [4:0]  wlen;
    logic [7:0]  r02;
    logic [23:0] l, r, el, er;
  } saivp_row_t;

  logic        clk, rst, hw_mode_pin, amp_shutdown_n, soft_clip_pin, reg_write;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        bit_clk, channel_select_clock, serial_data;
  logic        amp_fault_n_o, amp_fault_n_oe_n, power_stage_en, double_speed;
  logic        audio_valid, audio_left;
  logic [23:0] audio_data, left, right, last_l, last_r;
  logic [1:0]  fmt;
  logic [5:0]  slot;
  logic [4:0]  wlen;
  int          fails, tests_run, n_valid, base;

  // Format, length, slot, word bits, reg filter_bypass_control, inputs, expected outputs
  saivp_row_t rows [8] = '{
    '{2'h0, 2'h0, 6'h20, 5'd24, 8'h80, 24'h123456, 24'hfedcba, 24'h123456, 24'hfedcba},
    '{2'h0, 2'h0, 6'h18, 5'd24, 8'h80, 24'h800001, 24'h7ffffe, 24'h800001, 24'h7ffffe},
    '{2'h0, 2'h3, 6'h10, 5'd16, 8'h80, 24'habcdff, 24'h5432aa, 24'habcd00, 24'h543200},
    '{2'h1, 2'h1, 6'h20, 5'd20, 8'h80, 24'h9abcde, 24'h13579b, 24'h9abcd0, 24'h135790},
    '{2'h1, 2'h2, 6'h20, 5'd18, 8'h80, 24'hffffff, 24'h00003f, 24'hffffc0, 24'h000000},
    '{2'h2, 2'h0, 6'h20, 5'd24, 8'h80, 24'h00ff01, 24'hff00fe, 24'h00ff01, 24'hff00fe},
    '{2'h2, 2'h0, 6'h18, 5'd24, 8'h80, 24'h3c3c3c, 24'hc3c3c3, 24'h3c3c3c, 24'hc3c3c3},
    '{2'h0, 2'h0, 6'h20, 5'd24, 8'h81, 24'h100000, 24'hf00000, 24'h200000, 24'he00000}
  };

  saivp_top i_saivp_top (.clk(clk), .rst(rst), .bit_clk(bit_clk), .channel_select_clock(channel_select_clock),
    .serial_data(serial_data), .hw_mode_pin(hw_mode_pin), .amp_shutdown_n(amp_shutdown_n),
    .soft_clip_pin(soft_clip_pin), .amp_fault_n_o(amp_fault_n_o), .amp_fault_n_oe_n(amp_fault_n_oe_n),
    .power_stage_en(power_stage_en), .double_speed(double_speed), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .audio_valid(audio_valid),
    .audio_left(audio_left), .audio_data(audio_data));

  saivp_src_model i_saivp_src_model (.fmt(fmt), .slot(slot), .wlen(wlen), .left(left), .right(right),
    .bit_clk(bit_clk), .channel_select_clock(channel_select_clock), .serial_data(serial_data));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (audio_valid === 1'b1) begin
      n_valid <= n_valid + 1;
      if (audio_left) last_l <= audio_data;
      else last_r <= audio_data;
    end
  end

  task check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      fails++;
    end
  endtask : check

  task results;
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  // Read data is registered one cycle behind the address
  task rd(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 check({16'h0, reg_rdata & mask}, {16'h0, exp});
  endtask : rd

  task burst(input logic [1:0] f, input logic [5:0] s, input logic [4:0] w, input logic [23:0] l,
             input logic [23:0] r, input int n);
    @(posedge clk);
    fmt <= f;
    slot <= s;
    wlen <= w;
    left <= l;
    right <= r;
    last_l <= 24'hx;
    last_r <= 24'hx;
    @(posedge clk);
    i_saivp_src_model.send_frames(n);
    repeat (12) @(posedge clk);
  endtask : burst

  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    results();
  end

  initial begin
    clk = 1'b0; rst = 1'b1; hw_mode_pin = 1'b0; amp_shutdown_n = 1'b1; soft_clip_pin = 1'b0;
    reg_write = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; fmt = 2'h0; slot = 6'h20; wlen = 5'd24;
    left = 24'h0; right = 24'h0; fails = 0; tests_run = 0; n_valid = 0;
    repeat (16) @(posedge clk);
    // Link logic needs bit clock edges while held in reset
    i_saivp_src_model.send_frames(1);
    @(posedge clk) rst <= 1'b0;
    repeat (5) @(posedge clk);
    check({23'h0, power_stage_en}, 24'h1);
    check({23'h0, amp_fault_n_oe_n}, 24'h1);
    rd(saivp_pkg::ADDR_FILTER, 8'hff, saivp_pkg::RST_FILTER);
    rd(saivp_pkg::ADDR_FORMAT, 8'hff, saivp_pkg::RST_FORMAT);
    rd(saivp_pkg::ADDR_VOLUME, 8'hff, saivp_pkg::RST_VOLUME);
    rd(saivp_pkg::ADDR_VOLCFG, 8'hff, saivp_pkg::RST_VOLCFG);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'hff, 8'h00);
    @(posedge clk) soft_clip_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rd(saivp_pkg::ADDR_STATUS, 8'h04, 8'h04);
    wr(saivp_pkg::ADDR_FORMAT, 8'h08);
    repeat (3) @(posedge clk);
    check({23'h0, double_speed}, 24'h1);
    wr(saivp_pkg::ADDR_VOLCFG, 8'h80);
    for (int i = 0; i < 8; i++) begin
      wr(saivp_pkg::ADDR_FILTER, rows[i].r02);
      wr(saivp_pkg::ADDR_FORMAT, {2'h0, rows[i].len, 2'h0, rows[i].fmt});
      burst(rows[i].fmt, rows[i].slot, rows[i].wlen, rows[i].l, rows[i].r, 3);
      check(last_l, rows[i].el);
      check(last_r, rows[i].er);
    end
    // Mute and the top of the gain range
    wr(saivp_pkg::ADDR_FILTER, 8'h80);
    wr(saivp_pkg::ADDR_FORMAT, 8'h00);
    wr(saivp_pkg::ADDR_VOLUME, saivp_pkg::VOL_MUTE);
    burst(2'h0, 6'h20, 5'd24, 24'h400000, 24'hc00000, 3);
    check(last_l, 24'h0);
    wr(saivp_pkg::ADDR_VOLUME, 8'hff);
    burst(2'h0, 6'h20, 5'd24, 24'h010000, 24'hff0000, 3);
    check(last_l, 24'h100000);
    check(last_r, 24'hf00000);
    // Ramp: one step per eight frames, then immediate apply with ramp off
    wr(saivp_pkg::ADDR_VOLUME, 8'hcf);
    wr(saivp_pkg::ADDR_VOLCFG, 8'h00);
    wr(saivp_pkg::ADDR_VOLUME, 8'hd1);
    rd(saivp_pkg::ADDR_APPLIED, 8'hff, 8'hcf);
    burst(2'h0, 6'h20, 5'd24, 24'h010000, 24'h010000, 8);
    rd(saivp_pkg::ADDR_APPLIED, 8'hff, 8'hd0);
    burst(2'h0, 6'h20, 5'd24, 24'h010000, 24'h010000, 9);
    rd(saivp_pkg::ADDR_APPLIED, 8'hff, 8'hd1);
    wr(saivp_pkg::ADDR_VOLCFG, 8'h80);
    wr(saivp_pkg::ADDR_VOLUME, 8'hc0);
    burst(2'h0, 6'h20, 5'd24, 24'h010000, 24'h010000, 1);
    rd(saivp_pkg::ADDR_APPLIED, 8'hff, 8'hc0);
    wr(saivp_pkg::ADDR_VOLUME, 8'hcf);
    // Hardware mode: single speed, odd ratios dropped
    @(posedge clk) hw_mode_pin <= 1'b1;
    repeat (4) @(posedge clk);
    wr(saivp_pkg::ADDR_FORMAT, 8'h08);
    repeat (4) @(posedge clk);
    check({23'h0, double_speed}, 24'h0);
    rd(saivp_pkg::ADDR_STATUS, 8'h02, 8'h02);
    base = n_valid;
    burst(2'h0, 6'd20, 5'd20, 24'h111110, 24'h222220, 3);
    // Only the right word left pending by the previous burst gets out
    check(24'(n_valid - base), 24'h000001);
    base = n_valid;
    burst(2'h0, 6'h20, 5'd24, 24'h111111, 24'h222222, 3);
    // Three left and two right words; the odd slot left over before is dropped
    check(24'(n_valid - base), 24'h000005);
    @(posedge clk) hw_mode_pin <= 1'b0;
    // Long same-sign full-scale output latches the DC fault
    wr(saivp_pkg::ADDR_FILTER, 8'h80);
    wr(saivp_pkg::ADDR_FORMAT, 8'h30);
    burst(2'h0, 6'h10, 5'd16, 24'h7fff00, 24'h7fff00, 1100);
    check({23'h0, power_stage_en}, 24'h0);
    check({22'h0, amp_fault_n_oe_n, amp_fault_n_o}, 24'h0);
    rd(saivp_pkg::ADDR_STATUS, 8'h01, 8'h01);
    @(posedge clk) amp_shutdown_n <= 1'b0;
    repeat (8) @(posedge clk);
    amp_shutdown_n <= 1'b1;
    repeat (8) @(posedge clk);
    check({23'h0, amp_fault_n_oe_n}, 24'h1);
    check({23'h0, power_stage_en}, 24'h1);
    results();
  end
endmodule : saivp_top_tb
